/* File: vcc_pkg.sv */
package vcc_pkg;
  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] VCC_CTRL_OFF = 4'h0;
  localparam logic [3:0] VCC_IRQ_STAT_OFF = 4'h4;
  localparam logic [3:0] VCC_IRQ_CLR_OFF = 4'h8;
  localparam logic [3:0] VCC_IRQ_EN_OFF = 4'hc;
  localparam logic [15:0] VCC_CTRL_RESET = 16'h0000;
  localparam logic [15:0] VCC_CTRL_WMASK = 16'h07ff;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int VCC_ON_BIT = 10;
  localparam int VCC_NSEL_LSB = 8;
  localparam int VCC_ROUTE_LSB = 6;
  localparam int VCC_POL_BIT = 5;
  localparam int VCC_RESP_LSB = 3;
  localparam int VCC_HYST_BIT = 2;
  localparam int VCC_RISE_BIT = 1;
  localparam int VCC_FALL_BIT = 0;
  // ****************************************
  // field encodings
  // ****************************************
  localparam logic [1:0] VCC_ROUTE_LOGIC = 2'h2;
  localparam logic [1:0] VCC_ROUTE_IRQ = 2'h3;
  localparam logic [1:0] VCC_NSEL_RSVD = 2'h3;
  localparam logic [1:0] VCC_RESP_RSVD_A = 2'h1;
  localparam logic [1:0] VCC_RESP_RSVD_B = 2'h2;
  localparam logic [1:0] VCC_AXI_OKAY = 2'h0;
  localparam logic [1:0] VCC_AXI_SLVERR = 2'h2;
  // ****************************************
  // analog-side controls
  // ****************************************
  typedef struct packed {
    logic on;
    logic [1:0] neg_sel;
    logic polarity;
    logic [1:0] response;
    logic hysteresis;
  } vcc_analog_t;
endpackage

/* File: vcc_top.sv */
`timescale 1ns/100ps
module vcc_top
  import vcc_pkg::*;
#(
  parameter int ADDR_W = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic comparator_raw,
  output vcc_analog_t analog_ctrl,
  output logic positive_input_to_channel_three,
  output logic negative_input_from_channel_four,
  output logic comparator_irq,
  output logic programmable_logic_array,
  output logic adc_start_trigger,
  output logic comparator_output_pin,
  output logic irq
);

  // address must reach every register offset
  if (ADDR_W < 4) begin : g_addr_check
    $error("ADDR_W must be at least 4");
  end

  // ****************************************
  // axi4-lite handshake state
  // ****************************************
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d, araddr_q, araddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_fire;
  logic [3:0] wr_off, rd_off;

  assign wr_fire = aw_q && w_q && !b_q;
  assign wr_off = awaddr_q[3:0];
  assign rd_off = araddr_q[3:0];

  // ****************************************
  // block state
  // ****************************************
  logic [15:0] ctrl_q, ctrl_d;
  logic [1:0] irq_en_q, irq_en_d;
  logic sync1_q, sync2_q, prev_q;
  logic sync1_d, sync2_d, prev_d;
  logic rise, fall, cmp_out;
  logic [7:0] out_q, out_d;

  // address and data caught separately, either order
  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    b_d = b_q;
    bresp_d = bresp_q;
    if (!aw_q && s_axi_awvalid) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (!w_q && s_axi_wvalid) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = (wr_off == VCC_CTRL_OFF || wr_off == VCC_IRQ_CLR_OFF
                 || wr_off == VCC_IRQ_EN_OFF) ? VCC_AXI_OKAY : VCC_AXI_SLVERR;
    end
    if (b_q && s_axi_bready) begin
      b_d = 1'b0;
    end
  end

  // read: address captured and data answered on the same edge
  always_comb begin
    r_d = r_q;
    araddr_d = araddr_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (!r_q && s_axi_arvalid) begin
      r_d = 1'b1;
      araddr_d = s_axi_araddr;
      rresp_d = VCC_AXI_OKAY;
      case (s_axi_araddr[3:0])
        VCC_CTRL_OFF: rdata_d = {16'h0000, ctrl_q};
        VCC_IRQ_STAT_OFF: rdata_d = {30'h0000_0000, ctrl_q[VCC_RISE_BIT:VCC_FALL_BIT]};
        VCC_IRQ_CLR_OFF: rdata_d = 32'h0000_0000;
        VCC_IRQ_EN_OFF: rdata_d = {30'h0000_0000, irq_en_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = VCC_AXI_SLVERR;
        end
      endcase
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  // synchroniser and edge detect
  always_comb begin
    sync1_d = comparator_raw;
    sync2_d = sync1_q;
    cmp_out = ctrl_q[VCC_ON_BIT] && (sync2_q ^ ctrl_q[VCC_POL_BIT]);
    prev_d = cmp_out;
    rise = cmp_out && !prev_q;
    fall = !cmp_out && prev_q;
  end

  // control register and sticky edge flags
  always_comb begin
    ctrl_d = ctrl_q;
    irq_en_d = irq_en_q;
    if (wr_fire && wr_off == VCC_CTRL_OFF) begin
      if (wstrb_q[0]) begin
        ctrl_d[7:2] = wdata_q[7:2];
        if (wdata_q[VCC_RISE_BIT]) begin
          ctrl_d[VCC_RISE_BIT] = 1'b0;
        end
        if (wdata_q[VCC_FALL_BIT]) begin
          ctrl_d[VCC_FALL_BIT] = 1'b0;
        end
      end
      if (wstrb_q[1]) begin
        ctrl_d[10:8] = wdata_q[10:8] & VCC_CTRL_WMASK[10:8];
      end
      if (wstrb_q[0] && (wdata_q[4:3] == VCC_RESP_RSVD_A
                         || wdata_q[4:3] == VCC_RESP_RSVD_B)) begin
        ctrl_d[4:3] = ctrl_q[4:3];
      end
    end
    if (wr_fire && wr_off == VCC_IRQ_CLR_OFF && wstrb_q[0]) begin
      if (wdata_q[VCC_RISE_BIT]) begin
        ctrl_d[VCC_RISE_BIT] = 1'b0;
      end
      if (wdata_q[VCC_FALL_BIT]) begin
        ctrl_d[VCC_FALL_BIT] = 1'b0;
      end
    end
    if (wr_fire && wr_off == VCC_IRQ_EN_OFF && wstrb_q[0]) begin
      irq_en_d = wdata_q[1:0];
    end
    if (!ctrl_q[VCC_ON_BIT] && ctrl_d[VCC_ON_BIT]) begin
      ctrl_d[VCC_RISE_BIT] = 1'b1;
    end
    if (rise) begin
      ctrl_d[VCC_RISE_BIT] = 1'b1;
    end
    if (fall) begin
      ctrl_d[VCC_FALL_BIT] = 1'b1;
    end
  end

  // registered outputs
  always_comb begin
    out_d = '0;
    out_d[0] = (ctrl_q[7:6] == VCC_ROUTE_IRQ) && (rise || fall
               || ctrl_q[VCC_RISE_BIT] || ctrl_q[VCC_FALL_BIT]);
    out_d[1] = (ctrl_q[7:6] == VCC_ROUTE_LOGIC) && cmp_out;
    out_d[2] = rise;
    out_d[3] = cmp_out;
    out_d[4] = ctrl_q[VCC_ON_BIT];
    out_d[5] = ctrl_q[VCC_ON_BIT] && (ctrl_q[9:8] == 2'h1);
    out_d[6] = |(ctrl_d[1:0] & irq_en_d);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awaddr_q <= '0;
      araddr_q <= '0;
      wdata_q <= '0;
      rdata_q <= '0;
      wstrb_q <= '0;
      bresp_q <= VCC_AXI_OKAY;
      rresp_q <= VCC_AXI_OKAY;
      ctrl_q <= VCC_CTRL_RESET;
      irq_en_q <= 2'h0;
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      out_q <= '0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awaddr_q <= awaddr_d;
      araddr_q <= araddr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      wstrb_q <= wstrb_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      ctrl_q <= ctrl_d;
      irq_en_q <= irq_en_d;
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      prev_q <= prev_d;
      out_q <= out_d;
    end
  end

  // ****************************************
  // port drive
  // ****************************************
  assign s_axi_awready = !aw_q;
  assign s_axi_wready = !w_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign analog_ctrl = '{on: ctrl_q[VCC_ON_BIT], neg_sel: ctrl_q[9:8],
                         polarity: ctrl_q[VCC_POL_BIT], response: ctrl_q[4:3],
                         hysteresis: ctrl_q[VCC_HYST_BIT]};
  assign comparator_irq = out_q[0];
  assign programmable_logic_array = out_q[1];
  assign adc_start_trigger = out_q[2];
  assign comparator_output_pin = out_q[3];
  assign positive_input_to_channel_three = out_q[4];
  assign negative_input_from_channel_four = out_q[5];
  assign irq = out_q[6];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rise_set;
    rise |=> ctrl_q[VCC_RISE_BIT];
  endproperty
  a_rise_set: assert property (p_rise_set) else $error("rise lost");

  property p_fall_set;
    fall |=> ctrl_q[VCC_FALL_BIT];
  endproperty
  a_fall_set: assert property (p_fall_set) else $error("fall lost");

  property p_on_flag;
    $rose(ctrl_q[VCC_ON_BIT]) |-> ctrl_q[VCC_RISE_BIT];
  endproperty
  a_on_flag: assert property (p_on_flag) else $error("no turn-on flag");

  property p_rsvd;
    ctrl_q[15:11] == 5'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");

  property p_resp;
    ctrl_q[4:3] != VCC_RESP_RSVD_A && ctrl_q[4:3] != VCC_RESP_RSVD_B;
  endproperty
  a_resp: assert property (p_resp) else $error("reserved response");

  sequence s_edge_seen;
    $changed(sync2_q) && ctrl_q[VCC_ON_BIT] && $stable(ctrl_q[VCC_ON_BIT])
      && $stable(ctrl_q[VCC_POL_BIT]);
  endsequence
  property p_sync;
    s_edge_seen |-> (rise || fall);
  endproperty
  a_sync: assert property (p_sync) else $error("edge missed");

  property p_logic_route;
    ##1 programmable_logic_array |-> $past(ctrl_q[7:6]) == VCC_ROUTE_LOGIC;
  endproperty
  a_logic_route: assert property (p_logic_route) else $error("logic route wrong");

  property p_pin;
    !ctrl_q[VCC_ON_BIT] ##1 !ctrl_q[VCC_ON_BIT] |=> !comparator_output_pin;
  endproperty
  a_pin: assert property (p_pin) else $error("pin high when off");
endmodule

/* File: vcc_analog_model.sv */
`timescale 1ns/100ps
// ****************************************
// analog comparator stand-in
// ****************************************
module vcc_analog_model
  import vcc_pkg::*;
(
  input wire logic aclk,
  input vcc_analog_t analog_ctrl,
  input wire logic pos_above,
  output logic comparator_raw
);
  // unpowered comparator output is junk, so toggle it to catch missing gating
  // raw sense before polarity
  always @(posedge aclk) begin
    if (analog_ctrl.on) begin
      comparator_raw <= pos_above;
    end else begin
      comparator_raw <= ~comparator_raw;
    end
  end
  initial comparator_raw = 1'b0;
endmodule

/* File: voltage_comparator_control_test.sv */
`timescale 1ns/100ps
module voltage_comparator_control_test;
  import vcc_pkg::*;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, pos_above = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, rd_q;
  logic awready, wready, bvalid, arready, rvalid, raw, cirq, logic_out, trig, pin, ch3, ch4, irq;
  logic [1:0] bresp, rresp, br_q, rr_q;
  vcc_analog_t actl;
  int error_cnt = 0, checks_done = 0, trig_cnt = 0, t0;
  // ****************************************
  // clock, units under test
  // ****************************************
  always #4 aclk = ~aclk;
  always @(posedge aclk) if (trig === 1'b1) trig_cnt++;
  vcc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .comparator_raw(raw), .analog_ctrl(actl),
    .positive_input_to_channel_three(ch3), .negative_input_from_channel_four(ch4),
    .comparator_irq(cirq), .programmable_logic_array(logic_out), .adc_start_trigger(trig),
    .comparator_output_pin(pin), .irq(irq));
  vcc_analog_model partner (.aclk(aclk), .analog_ctrl(actl), .pos_above(pos_above),
    .comparator_raw(raw));
  // ****************************************
  // bus and check helpers
  // ****************************************
  // ready lines low while busy, so each channel drops only once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    br_q = bresp;
  endtask
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_q = rdata;
    rr_q = rresp;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic settle();
    repeat (6) @(posedge aclk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rd(VCC_CTRL_OFF);
    chk("ctrl", 32'h0000_0000, rd_q);
    rd(VCC_IRQ_STAT_OFF);
    chk("stat", 32'h0000_0000, rd_q);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    rd(4'h2);
    chk("rresp", {30'h0, VCC_AXI_SLVERR}, {30'h0, rr_q});
    chk("rdata", 32'h0000_0000, rd_q);
    wr(4'h2, 32'h0000_07ff);
    chk("bresp", {30'h0, VCC_AXI_SLVERR}, {30'h0, br_q});
    rd(VCC_CTRL_OFF);
    chk("ctrl", 32'h0000_0000, rd_q);
  endtask
  task automatic t_config();
    wr(VCC_CTRL_OFF, 32'h0000_06f8);
    chk("bresp", {30'h0, VCC_AXI_OKAY}, {30'h0, br_q});
    settle();
    rd(VCC_CTRL_OFF);
    chk("ctrl", 32'h0000_06f8, {rd_q[31:2], 2'b00});
    chk("rresp", {30'h0, VCC_AXI_OKAY}, {30'h0, rr_q});
    wr(VCC_CTRL_OFF, 32'h0000_06f0);
    rd(VCC_CTRL_OFF);
    chk("resp_kept", 32'h0000_06f8, {rd_q[31:2], 2'b00});
    chk("actl", 32'h0000_006e, {25'h0, actl});
    chk("ch3", 32'h0000_0001, {31'h0, ch3});
    chk("ch4", 32'h0000_0000, {31'h0, ch4});
    rd(VCC_IRQ_STAT_OFF);
    chk("on_flag", 32'h0000_0001, {31'h0, rd_q[1]});
  endtask
  task automatic t_irq();
    wr(VCC_IRQ_CLR_OFF, 32'h0000_0003);
    wr(VCC_IRQ_EN_OFF, 32'h0000_0003);
    rd(VCC_IRQ_STAT_OFF);
    chk("stat", 32'h0000_0000, rd_q);
    pos_above <= 1'b1;
    settle();
    rd(VCC_IRQ_STAT_OFF);
    chk("stat", 32'h0000_0001, rd_q);
    chk("pin", 32'h0000_0000, {31'h0, pin});
    chk("cirq", 32'h0000_0001, {31'h0, cirq});
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(VCC_CTRL_OFF, 32'h0000_06f9);
    rd(VCC_IRQ_STAT_OFF);
    chk("stat", 32'h0000_0000, rd_q);
    chk("irq", 32'h0000_0000, {31'h0, irq});
  endtask
  task automatic t_logic_route();
    pos_above <= 1'b0;
    wr(VCC_CTRL_OFF, 32'h0000_0584);
    settle();
    chk("actl", 32'h0000_0051, {25'h0, actl});
    wr(VCC_IRQ_CLR_OFF, 32'h0000_0003);
    t0 = trig_cnt;
    pos_above <= 1'b1;
    settle();
    chk("trig", t0 + 1, trig_cnt);
    chk("logic_route", 32'h0000_0001, {31'h0, logic_out});
    chk("pin", 32'h0000_0001, {31'h0, pin});
    chk("cirq", 32'h0000_0000, {31'h0, cirq});
    chk("ch4", 32'h0000_0001, {31'h0, ch4});
    rd(VCC_IRQ_STAT_OFF);
    chk("stat", 32'h0000_0002, rd_q);
    wr(VCC_CTRL_OFF, 32'h0000_0586);
    rd(VCC_IRQ_STAT_OFF);
    chk("stat", 32'h0000_0000, rd_q);
  endtask
  task automatic t_off();
    wr(VCC_CTRL_OFF, 32'h0000_f800);
    settle();
    rd(VCC_CTRL_OFF);
    chk("ctrl", 32'h0000_0000, {rd_q[31:2], 2'b00});
    chk("pin", 32'h0000_0000, {31'h0, pin});
    chk("ch3", 32'h0000_0000, {31'h0, ch3});
    chk("actl", 32'h0000_0000, {25'h0, actl});
  endtask
  // ****************************************
  // run control
  // ****************************************
  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // whole run is about a hundred cycles, so this cap only trips on a hang
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_config();
    t_irq();
    t_logic_route();
    t_off();
    complete_run();
  end
endmodule
